// ### core/hub_boot_stage_sequencer.sv
/*
 Boot and mode sequencer of the hub. Steps from standby through flash
 check, configuration read, strap test, SOC configuration, merge,
 charger detection, connect and normal operation.
 Assumes straps and pins arrive asynchronous; reset pin is active low.
*/
// Functional notes
// - Reset low keeps standby, only reset watched
// - Standby disables ports, tristates, halts PLL
// - Reset high runs boot stages in order
// - No configuration survives standby
// - Release enters init, locks PLL, defaults
// - Read flash signature and compare
// - Match enables flash, fetch from zero
// - Mismatch stays on ROM, config read
// - Flash port single or dual data
// - Flash port supports mode 0 and 3
// - No flash strap skips flash check
// - Load ROM defaults, then strap overrides
// - Slave strap with pull-ups enters SOC
// - SOC configures without any timeout
// - Termination register write exits SOC stage
// - Merge ROM, SOC and OTP settings
// - Idle then suspend without bus power or connect request
// - Bus power goes charger or connect
// - Connect after charger, hold while powered
// - Normal mode runs hub under host
// - OTP over USB runtime, SMBus SOC only
// - Slave strap with pull-ups makes SMBus hub slave
`timescale 1ns/1ps
`default_nettype none
module hub_boot_stage_sequencer
	import hub_boot_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        chip_reset_n,
	input  wire logic        flash_strap,
	input  wire logic        flash_dual,
	input  wire logic        flash_mode3,
	input  wire logic [2:0]  config_strap,
	input  wire logic [7:0]  strap_conf,
	input  wire logic        sm_serial_data_pin,
	input  wire logic        sm_serial_clock_pin,
	input  wire logic        sm_wr,
	input  wire logic [7:0]  sm_addr,
	input  wire logic [7:0]  sm_wdata,
	input  wire logic [7:0]  rom_conf,
	input  wire logic [7:0]  otp_conf,
	input  wire logic        vbus,
	input  wire logic        hub_connect_req,
	input  wire logic        charge_enable,
	input  wire logic        pll_clock_ok,
	input  wire logic        mode_change,
	input  wire logic        otp_usb_req,
	input  wire logic        otp_sm_req,
	input  wire logic [1:0]  flash_miso,
	output logic             flash_sck,
	output logic             flash_cs_n,
	output logic             flash_mosi,
	output logic             pll_run,
	output logic             ports_enable,
	output logic             usb_data_oe,
	output logic             smbus_slave_mode,
	output logic             external_code,
	output logic [15:0]      fetch_addr,
	output logic [7:0]       hub_conf,
	output logic             hub_connect,
	output logic             hub_suspend,
	output logic             charger_detect_stage,
	output logic             otp_grant,
	output logic [3:0]       stage
);

	stage_type state;         // Current stage
	stage_type next_state;    // Next stage

	// Two-stage synchronisers for reset, bus power, SMBus pins, connect and strap code
	logic [1:0] rst_sync;     // Chip reset pin
	logic [1:0] vbus_sync;    // Bus power
	logic [1:0] sda_sync;     // Data pin pull-up sense
	logic [1:0] scl_sync;     // Clock pin pull-up sense
	logic [1:0] conn_sync;    // Connect condition
	logic [2:0] strap_meta;   // Strap code, first flop
	logic [2:0] strap_sync;   // Strap code, second flop
	logic       rst_seen;     // Synchronised reset, delayed
	logic       rst_rise;     // Reset pin low-to-high

	logic [7:0] soc_conf;     // Settings written by the SOC
	logic       soc_written;  // SOC touched the setting
	logic [7:0] cfg_work;     // Working configuration
	logic [2:0] strap_latch;  // Strap caught before strap stage
	logic [7:0] cnt;          // Stage timer
	logic       sig_start;    // Kick the flash reader
	logic       sig_done;     // Reader finished
	logic       sig_match;    // Signature matched
	logic       term_write;   // Termination register hit

	// Reset, bus power, SMBus, connect and strap pins cross in through two flops each
	always_ff @(posedge clk) begin
		if (rst) begin
			rst_sync  <= 2'h0;
			vbus_sync <= 2'h0;
			sda_sync  <= 2'h0;
			scl_sync  <= 2'h0;
			conn_sync <= 2'h0;
			strap_meta <= 3'h0;
			strap_sync <= 3'h0;
			rst_seen  <= 1'b0;
		end else begin
			rst_sync  <= {rst_sync[0], chip_reset_n};
			vbus_sync <= {vbus_sync[0], vbus};
			sda_sync  <= {sda_sync[0], sm_serial_data_pin};
			scl_sync  <= {scl_sync[0], sm_serial_clock_pin};
			conn_sync <= {conn_sync[0], hub_connect_req};
			strap_meta <= config_strap;
			strap_sync <= strap_meta;
			rst_seen  <= rst_sync[1];
		end
	end

	// Edge taken from the second flop only
	assign rst_rise = rst_sync[1] && !rst_seen;

	// Termination write only counts in the SOC stage
	assign term_write = sm_wr && (sm_addr == CONFIG_DONE_TRIGGER)
		&& (state == ST_SOC_CFG);

	// Stage timer, reloaded on every stage change
	always_ff @(posedge clk) begin
		if (rst || state != next_state)
			cnt <= 8'h00;
		else if (cnt != 8'hff)
			cnt <= cnt + 8'h01;
	end

	// Next-stage decision
	always_comb begin
		next_state = state;
		unique case (state)
			ST_STANDBY:
				if (rst_rise)
					next_state = ST_INIT;
			ST_INIT:
				// Wait for PLL lock time from init entry, and for a valid clock
				if (pll_clock_ok && cnt >= 8'(PLL_LOCK_CYC - 1)) begin
					if (flash_strap)
						next_state = ST_FLASH_CHECK;
					else
						next_state = ST_CFG_READ;
				end
			ST_FLASH_CHECK:
				if (sig_done) begin
					if (sig_match)
						next_state = ST_NORMAL;
					else
						next_state = ST_CFG_READ;
				end
			ST_CFG_READ:
				next_state = ST_STRAP;
			ST_STRAP:
				if (strap_latch == SLAVE_CONFIG_SETTING
				    && sda_sync[1] && scl_sync[1])
					next_state = ST_SOC_CFG;
				else
					next_state = ST_MERGE;
			ST_SOC_CFG:
				// No timeout: only the termination write ends it
				if (term_write)
					next_state = ST_MERGE;
			ST_MERGE:
				next_state = ST_IDLE;
			ST_IDLE, ST_SUSPEND:
				if (vbus_sync[1])
					next_state = charge_enable ? ST_CHARGER
						: ST_CONNECT;
				else if (!conn_sync[1])
					next_state = ST_SUSPEND;
				else
					next_state = ST_IDLE;
			ST_CHARGER:
				if (cnt >= 8'(CHG_DET_CYC - 1))
					next_state = ST_CONNECT;
			ST_CONNECT:
				if (!vbus_sync[1])
					next_state = ST_IDLE;
				else
					next_state = ST_NORMAL;
			ST_NORMAL:
				// Stays until the system changes mode, or bus power drops while running from ROM
				if (mode_change || (!external_code && !vbus_sync[1]))
					next_state = ST_IDLE;
		endcase
		// Reset pin low overrides everything
		if (!rst_sync[1])
			next_state = ST_STANDBY;
	end

	// Stage register
	always_ff @(posedge clk) begin
		if (rst)
			state <= ST_STANDBY;
		else
			state <= next_state;
	end

	// Strap capture, clocked so reset never loads a pin
	always_ff @(posedge clk) begin
		if (rst || state == ST_STANDBY)
			strap_latch <= STRAP_RESET;
		else if (state == ST_CFG_READ)
			// One stage early, so the strap stage decides on it
			strap_latch <= strap_sync;
	end

	// SOC-written settings; any address below the trigger
	always_ff @(posedge clk) begin
		if (rst || state == ST_STANDBY) begin
			soc_conf    <= CONF_RESET;
			soc_written <= 1'b0;
		end else if (state == ST_SOC_CFG && sm_wr
		             && sm_addr != CONFIG_DONE_TRIGGER) begin
			soc_conf    <= sm_wdata;
			soc_written <= 1'b1;
		end
	end

	// Working configuration built stage by stage
	always_ff @(posedge clk) begin
		if (rst || state == ST_STANDBY || state == ST_INIT)
			cfg_work <= CONF_RESET;
		else if (state == ST_CFG_READ)
			cfg_work <= rom_conf | strap_conf;
		else if (state == ST_MERGE)
			// OTP bits layered over SOC or ROM values
			cfg_work <= (soc_written ? soc_conf : cfg_work)
				| otp_conf;
	end

	// Flash fetch control
	always_ff @(posedge clk) begin
		if (rst || state == ST_STANDBY) begin
			external_code <= 1'b0;
			fetch_addr    <= CODE_ADDR;
			sig_start     <= 1'b0;
		end else begin
			sig_start <= (next_state == ST_FLASH_CHECK)
				&& (state != ST_FLASH_CHECK);
			if (state == ST_FLASH_CHECK && sig_done && sig_match) begin
				external_code <= 1'b1;
				fetch_addr    <= CODE_ADDR;
			end
		end
	end

	flash_sig_reader u_sig (
		.clk       (clk),
		.rst       (rst || state == ST_STANDBY),
		.start     (sig_start),
		.dual      (flash_dual),
		.cpol_mode (flash_mode3 ? SPI_MODE_3 : SPI_MODE_0),
		.miso      (flash_miso),
		.sck       (flash_sck),
		.cs_n      (flash_cs_n),
		.mosi      (flash_mosi),
		.done      (sig_done),
		.match     (sig_match)
	);

	// Stage-derived outputs, all from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_run              <= 1'b0;
			ports_enable         <= 1'b0;
			usb_data_oe          <= 1'b0;
			smbus_slave_mode     <= 1'b0;
			hub_conf             <= CONF_RESET;
			hub_connect          <= 1'b0;
			hub_suspend          <= 1'b0;
			charger_detect_stage <= 1'b0;
			otp_grant            <= 1'b0;
			stage                <= 4'h0;
		end else begin
			pll_run      <= next_state != ST_STANDBY;
			ports_enable <= next_state == ST_CONNECT
				|| next_state == ST_NORMAL;
			usb_data_oe  <= next_state == ST_CONNECT
				|| next_state == ST_NORMAL;
			// Slave only once strap and pull-ups both qualified
			smbus_slave_mode <= next_state != ST_STANDBY
				&& (next_state == ST_SOC_CFG
				|| smbus_slave_mode);
			if (state == ST_MERGE)
				hub_conf <= (soc_written ? soc_conf : cfg_work)
					| otp_conf;
			else if (next_state == ST_STANDBY)
				hub_conf <= CONF_RESET;
			hub_connect <= (next_state == ST_CONNECT
				|| next_state == ST_NORMAL) && vbus_sync[1];
			hub_suspend <= next_state == ST_SUSPEND;
			charger_detect_stage <= next_state == ST_CHARGER;
			otp_grant <= (next_state == ST_NORMAL && otp_usb_req)
				|| (next_state == ST_SOC_CFG && otp_sm_req);
			stage <= 4'(next_state);
		end
	end

	// Standby holds while reset pin stays low
	a_standby_hold: assert property (@(posedge clk) disable iff (rst)
		!rst_sync[1] |=> state == ST_STANDBY)
		else $error("left standby with reset low");

	// Named steps from reset release to init
	sequence s_release;
		state == ST_STANDBY && rst_rise;
	endsequence
	a_init_entry: assert property (@(posedge clk) disable iff (rst)
		s_release |=> state == ST_INIT)
		else $error("reset release did not reach init");

	a_pll_halt: assert property (@(posedge clk) disable iff (rst)
		state == ST_STANDBY ##1 state == ST_STANDBY
		|-> !pll_run && !usb_data_oe)
		else $error("standby with PLL or pins active");

	a_strap_soc: assert property (@(posedge clk) disable iff (rst)
		state == ST_STRAP && rst_sync[1]
		&& strap_latch == SLAVE_CONFIG_SETTING
		&& sda_sync[1] && scl_sync[1] |=> state == ST_SOC_CFG)
		else $error("slave strap with pull-ups missed SOC stage");

	a_soc_wait: assert property (@(posedge clk) disable iff (rst)
		state == ST_SOC_CFG && !term_write && rst_sync[1]
		|=> state == ST_SOC_CFG)
		else $error("SOC stage left without termination");

	a_term_exit: assert property (@(posedge clk) disable iff (rst)
		term_write && rst_sync[1] |=> state == ST_MERGE)
		else $error("termination write did not end SOC stage");

	a_skip_flash: assert property (@(posedge clk) disable iff (rst)
		state == ST_INIT && next_state != ST_INIT && !flash_strap
		&& rst_sync[1] |=> state == ST_CFG_READ)
		else $error("flash check not skipped");

	a_mismatch_rom: assert property (@(posedge clk) disable iff (rst)
		state == ST_FLASH_CHECK && sig_done && !sig_match
		&& rst_sync[1] |=> state == ST_CFG_READ ##1 !external_code)
		else $error("mismatch did not fall back to ROM");

	a_charge_path: assert property (@(posedge clk) disable iff (rst)
		state == ST_IDLE && vbus_sync[1] && charge_enable
		&& rst_sync[1] |=> state == ST_CHARGER
		##1 charger_detect_stage)
		else $error("charger detection skipped");

	a_otp_window: assert property (@(posedge clk) disable iff (rst)
		otp_grant |-> $past(state) inside {ST_SOC_CFG, ST_NORMAL}
		|| state inside {ST_SOC_CFG, ST_NORMAL})
		else $error("OTP granted outside allowed stages");

endmodule
`default_nettype wire

// ### core/hub_boot_pkg.sv
/*
 Package for the hub boot stage sequencer: stage enumeration, flash
 signature layout, strap codes, register offset and timing counts.
 Assumes a single 20 MHz core clock.
*/
package hub_boot_pkg;

	// Boot stages of the hub
	typedef enum logic [3:0] {
		ST_STANDBY,
		ST_INIT,
		ST_FLASH_CHECK,
		ST_CFG_READ,
		ST_STRAP,
		ST_SOC_CFG,
		ST_MERGE,
		ST_IDLE,
		ST_SUSPEND,
		ST_CHARGER,
		ST_CONNECT,
		ST_NORMAL
	} stage_type;

	// Strap code for the slave-configuration setting
	localparam logic [2:0]  SLAVE_CONFIG_SETTING = 3'h1;
	localparam logic [2:0]  STRAP_RESET          = 3'h0;

	// Flash image layout
	localparam logic [15:0] SIG_ADDR   = 16'hfffa;
	localparam logic [15:0] CODE_ADDR  = 16'h0000;
	localparam logic [31:0] SIG_WORD   = 32'h32444655;
	localparam int          SIG_BYTES  = 4;

	// Termination register offset
	localparam logic [7:0]  CONFIG_DONE_TRIGGER = 8'hff;

	// Flash port modes
	localparam logic        SPI_MODE_0 = 1'h0;
	localparam logic        SPI_MODE_3 = 1'h1;

	// Clock and timing
	localparam int CLK_MHZ        = 20;
	localparam int PLL_LOCK_NS    = 1000;
	localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
	localparam int CHG_DET_NS     = 2000;
	localparam int CHG_DET_CYC    = (CHG_DET_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CONF_RESET = 8'h00;

endpackage

// ### core/flash_sig_reader.sv
/*
 Serial flash signature reader. Issues a read at the signature address
 and shifts four bytes in over one or two data lines, modes 0 or 3.
 Assumes a flash that answers the plain read command, and synchronised
 data inputs from the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_sig_reader
	import hub_boot_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic        dual,
	input  wire logic        cpol_mode,
	input  wire logic [1:0]  miso,
	output logic             sck,
	output logic             cs_n,
	output logic             mosi,
	output logic             done,
	output logic             match
);

	localparam logic [31:0] CMD_ADDR = {8'h03, 8'h00, SIG_ADDR};

	logic        busy;   // Transfer running
	logic [6:0]  bitc;   // Bit counter, command then data
	logic        ph;     // Half-period phase
	logic [31:0] sh;     // Outgoing command shift
	logic [31:0] rx;     // Received signature

	// Idle clock level follows the mode: low for 0, high for 3
	// Transfer engine; data sampled on rising, shifted on falling
	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			bitc <= 7'h00;
			ph   <= 1'b0;
			sh   <= 32'h00000000;
			rx   <= 32'h00000000;
			sck  <= 1'b0;
			cs_n <= 1'b1;
			mosi <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				sck <= cpol_mode;
				if (start) begin
					busy <= 1'b1;
					cs_n <= 1'b0;
					// Mode 3 idles high: drop now so the first
					// rise samples the top bit instead of losing it
					sck  <= 1'b0;
					bitc <= 7'h00;
					ph   <= 1'b0;
					sh   <= {CMD_ADDR[30:0], 1'b0};
					mosi <= CMD_ADDR[31];
				end
			end else begin
				ph <= ~ph;
				if (!ph) begin
					// Rising edge: sample
					sck <= 1'b1;
					if (bitc >= 7'h20) begin
						if (dual)
							rx <= {rx[29:0], miso};
						else
							rx <= {rx[30:0], miso[0]};
					end
				end else begin
					// Falling edge: shift out next bit
					sck  <= 1'b0;
					mosi <= sh[31];
					sh   <= {sh[30:0], 1'b0};
					if ((dual && bitc == 7'h2f) ||
					    (!dual && bitc == 7'h3f)) begin
						busy <= 1'b0;
						cs_n <= 1'b1;
						done <= 1'b1;
					end
					bitc <= bitc + 7'h01;
				end
			end
		end
	end

	assign match = (rx == SIG_WORD);

endmodule
`default_nettype wire

// ### test/flash_model.sv
/*
 Behavioural serial flash holding one 32-bit word at the signature address.
 Assumes a reader that sends 32 header bits, then samples on rising clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_model (
	input  wire logic        flash_sck,
	input  wire logic        flash_cs_n,
	input  wire logic        flash_mosi,
	input  wire logic        dual,
	input  wire logic [31:0] image,
	output logic      [1:0]  miso,
	output logic      [31:0] header
);
	int k;     // Rising edges seen in this frame
	int bit_i; // Data step after the header

	// Known start; the lines carry no pull
	initial begin
		miso = 2'h2;
		header = 32'h0;
	end

	// New frame restarts the edge count
	always @(negedge flash_cs_n) begin
		k = 0;
	end

	// Deselected part: lines show the inverse, not a stale value
	always @(posedge flash_cs_n) begin
		miso <= ~miso;
	end

	// Header bits taken MSB first
	always @(posedge flash_sck) begin
		if (!flash_cs_n) begin
			if (k < 32)
				header <= {header[30:0], flash_mosi};
			k = k + 1;
		end
	end

	// Launch on falling clock so data is settled at the rise
	always @(negedge flash_sck) begin
		bit_i = k - 32;
		if (flash_cs_n || k < 32)
			bit_i = 99;
		if (dual && bit_i < 16)
			miso <= image[31 - 2 * bit_i -: 2];
		else if (!dual && bit_i < 32)
			miso <= {~miso[1], image[31 - bit_i]};
		else
			miso <= ~miso;
	end
endmodule
`default_nettype wire

// ### test/tb_hub_boot_stage_sequencer.sv
/*
 Testbench of the hub boot stage sequencer: standby, SOC configuration,
 charger path, re-boot without state, and flash boot in all port modes.
 Assumes the flash model beside it; all other pins are bench driven.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hub_boot_stage_sequencer
	import hub_boot_pkg::*;
;
	logic        clk = 1'h0, rst = 1'h1, chip_reset_n = 1'h0;
	logic        flash_strap = 1'h0, flash_dual = 1'h0, flash_mode3 = 1'h0;
	logic [2:0]  config_strap = 3'h0;
	logic [7:0]  strap_conf = 8'h01, rom_conf = 8'h80, otp_conf = 8'h06;
	logic        sda_pin = 1'h1, scl_pin = 1'h1, sm_wr = 1'h0;
	logic [7:0]  sm_addr = 8'h00, sm_wdata = 8'h00;
	logic        vbus = 1'h0, connect_req = 1'h0, charge_enable = 1'h0;
	logic        pll_clock_ok = 1'h0, mode_change = 1'h0;
	logic        otp_usb_req = 1'h0, otp_sm_req = 1'h0, seen_chg = 1'h0;
	logic [31:0] image = SIG_WORD;
	logic [31:0] header;
	logic [1:0]  flash_miso;
	logic        flash_sck, flash_cs_n, flash_mosi, pll_run, ports_enable;
	logic        usb_data_oe, smbus_slave_mode, external_code, hub_connect;
	logic        hub_suspend, charger_detect_stage, otp_grant;
	logic [15:0] fetch_addr;
	logic [7:0]  hub_conf;
	logic [3:0]  stage;
	int          fail_count = 0;
	int          tests_run = 0;

	// 20 MHz core clock
	always #25 clk = ~clk;

	hub_boot_stage_sequencer DUT (.clk(clk), .rst(rst),
		.chip_reset_n(chip_reset_n), .flash_strap(flash_strap),
		.flash_dual(flash_dual), .flash_mode3(flash_mode3),
		.config_strap(config_strap), .strap_conf(strap_conf),
		.sm_serial_data_pin(sda_pin), .sm_serial_clock_pin(scl_pin),
		.sm_wr(sm_wr), .sm_addr(sm_addr), .sm_wdata(sm_wdata),
		.rom_conf(rom_conf), .otp_conf(otp_conf), .vbus(vbus),
		.hub_connect_req(connect_req), .charge_enable(charge_enable),
		.pll_clock_ok(pll_clock_ok), .mode_change(mode_change),
		.otp_usb_req(otp_usb_req), .otp_sm_req(otp_sm_req),
		.flash_miso(flash_miso), .flash_sck(flash_sck),
		.flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi),
		.pll_run(pll_run), .ports_enable(ports_enable),
		.usb_data_oe(usb_data_oe), .smbus_slave_mode(smbus_slave_mode),
		.external_code(external_code), .fetch_addr(fetch_addr),
		.hub_conf(hub_conf), .hub_connect(hub_connect),
		.hub_suspend(hub_suspend),
		.charger_detect_stage(charger_detect_stage),
		.otp_grant(otp_grant), .stage(stage));

	flash_model FLASH (.flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
		.flash_mosi(flash_mosi), .dual(flash_dual), .image(image),
		.miso(flash_miso), .header(header));

	// Remembers any pass through charger detection
	always @(posedge clk) begin
		if (charger_detect_stage === 1'h1)
			seen_chg <= 1'h1;
	end

	// Value taken at the call, before this edge's updates land
	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
		@(posedge clk);
	endtask

	// Bounded wait for a stage code
	task automatic wait_stage(input logic [3:0] s, input int n);
		int i;
		i = 0;
		while (stage !== s && i < n) begin
			@(posedge clk);
			i++;
		end
		check("stage", {28'h0, s}, {28'h0, stage});
	endtask

	// One-cycle register write strobe
	task automatic sm_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sm_wr <= 1'h1;
		sm_addr <= a;
		sm_wdata <= d;
		@(posedge clk);
		sm_wr <= 1'h0;
	endtask

	// Chip reset pulse, long enough for the pin synchroniser
	task automatic reboot();
		@(posedge clk);
		chip_reset_n <= 1'h0;
		repeat (5) @(posedge clk);
		chip_reset_n <= 1'h1;
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Cuts a hang well past the expected run length
	initial begin
		#(50 * 40000);
		fail_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (10) @(posedge clk);
		check("stage", ST_STANDBY, stage);
		check("pins", 0, {pll_run, ports_enable, usb_data_oe});
		// SOC path: no clock yet, so init must hold
		config_strap <= SLAVE_CONFIG_SETTING;
		chip_reset_n <= 1'h1;
		repeat (60) @(posedge clk);
		check("stage", ST_INIT, stage);
		pll_clock_ok <= 1'h1;
		wait_stage(ST_SOC_CFG, 300);
		check("slave", 1, smbus_slave_mode);
		sm_write(8'h01, 8'h50);
		otp_sm_req <= 1'h1;
		repeat (2) @(posedge clk);
		check("otp_sm", 1, otp_grant);
		otp_sm_req <= 1'h0;
		repeat (200) @(posedge clk);
		check("stage", ST_SOC_CFG, stage);
		sm_write(CONFIG_DONE_TRIGGER, 8'h50);
		wait_stage(ST_SUSPEND, 20);
		check("suspend", 1, hub_suspend);
		check("conf", 8'h56, hub_conf);
		charge_enable <= 1'h1;
		vbus <= 1'h1;
		wait_stage(ST_CHARGER, 10);
		check("chg", 1, charger_detect_stage);
		wait_stage(ST_CONNECT, CHG_DET_CYC + 10);
		check("connect", 1, hub_connect);
		wait_stage(ST_NORMAL, 100);
		otp_sm_req <= 1'h1;
		repeat (2) @(posedge clk);
		check("otp_sm", 0, otp_grant);
		otp_sm_req <= 1'h0;
		otp_usb_req <= 1'h1;
		repeat (2) @(posedge clk);
		check("otp_usb", 1, otp_grant);
		otp_usb_req <= 1'h0;
		mode_change <= 1'h1;
		repeat (3) @(posedge clk);
		check("leave", 1, stage !== ST_NORMAL);
		mode_change <= 1'h0;
		// Re-boot, slave strap but no pull-up, no charging
		chip_reset_n <= 1'h0;
		sda_pin <= 1'h0;
		vbus <= 1'h0;
		charge_enable <= 1'h0;
		repeat (4) @(posedge clk);
		check("stage", ST_STANDBY, stage);
		// Cleared only once charger detection has surely ended
		seen_chg <= 1'h0;
		reboot();
		wait_stage(ST_SUSPEND, 300);
		check("slave", 0, smbus_slave_mode);
		check("conf", 8'h87, hub_conf);
		vbus <= 1'h1;
		wait_stage(ST_CONNECT, 10);
		check("no_chg", 0, seen_chg);
		// Flash boot over every width and mode, then a bad image
		flash_strap <= 1'h1;
		config_strap <= STRAP_RESET;
		vbus <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			flash_dual <= i[0];
			flash_mode3 <= i[1];
			image <= (i == 4) ? ~SIG_WORD : SIG_WORD;
			reboot();
			if (i < 4) begin
				wait_stage(ST_NORMAL, 2000);
				check("ext", 1, external_code);
				check("fetch", CODE_ADDR, fetch_addr);
			end else begin
				wait_stage(ST_SUSPEND, 2000);
				check("ext", 0, external_code);
			end
			check("header", {8'h03, 8'h00, SIG_ADDR}, header);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
